// File: logic/tap_debug.sv
// Boundary scan test port with chip port forwarding and boot sequencer
//
// What this block does
// RQ1: One standard test access port that scans the device I/O pins.
// RQ2: Instruction register is 4 bits; data register path is 32 bits for identification and usercode, 8 for boundary, 1 otherwise.
// RQ3: A dedicated instruction forwards the scan path to the internal chip port.
// RQ4: Far side holds test reset low at least 100 ns after power-up.
// RQ5: Test logic stays in reset while test reset is held low.
// RQ6: Identification instruction shifts out version, part number, maker identity.
// RQ7: Usercode instruction shifts out user ID, unused field, die revision.
// RQ8: User ID comes from security bits 31..22; zero when unprogrammed.
// RQ9: Chip reset is active low and asserts asynchronously on the boot sequencer and security word source; test logic resets on test reset only.
// RQ10: After chip reset release, wait for clock lock, then boot in chosen mode.
// RQ11: Far side holds chip reset low at least 100 ns after power-up.
// RQ12: Security bits 31..22 hold the user ID extension for usercode.
// RQ13: Security bit 0 set disables test access to tile state and memory.
// RQ14: Security bit 13 set blocks test access to the programmable memory.
// RQ15: Identification: 4-bit version, 16-bit part, 11-bit maker, bit 0 one.
// RQ16: States and capture, shift, update follow the standard clock and mode protocol.
`timescale 1ns/1ps
`default_nettype none
module tap_debug
    import tap_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    input  wire logic              pll_lock_i,
    input  wire logic [BOOT_W-1:0] boot_mode_i,
    input  wire logic [31:0]       security_i,
    input  wire logic              tck_i,
    input  wire logic              trst_n_i,
    input  wire logic              tms_i,
    input  wire logic              tdi_i,
    output logic                   tdo_o,
    output logic                   tdo_oe_o,
    input  wire logic [BSR_W-1:0]  pin_in_i,
    output logic      [BSR_W-1:0]  pin_out_o,
    output logic                   extest_o,
    input  wire logic              chip_tdo_i,
    output logic                   chip_sel_o,
    output logic                   chip_shift_o,
    output logic                   chip_tdi_o,
    output logic                   otp_access_o,
    output logic                   boot_run_o,
    output logic      [BOOT_W-1:0] boot_mode_o
);

    // ********************************
    // Boot sequencer, system clock
    // ********************************
    boot_t             boot_r;
    boot_t             boot_nxt;
    logic              lock_m_r;
    logic              lock_s_r;
    logic              strap_done_r;

    always_comb begin
        boot_nxt = boot_r;
        unique case (boot_r)
            BOOT_IDLE: boot_nxt = BOOT_LOCK;
            BOOT_LOCK: if (lock_s_r) boot_nxt = BOOT_RUN;
            BOOT_RUN:  boot_nxt = BOOT_RUN;
            default:   boot_nxt = BOOT_IDLE;
        endcase
    end

    // RQ9: async chip reset
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            boot_r       <= BOOT_IDLE;
            lock_m_r     <= 1'b0;
            lock_s_r     <= 1'b0;
            boot_run_o   <= 1'b0;
            strap_done_r <= 1'b0;
            boot_mode_o  <= '0;
        end else begin
            lock_m_r   <= pll_lock_i;
            lock_s_r   <= lock_m_r;
            boot_r     <= boot_nxt;
            // RQ10: boot after lock
            boot_run_o <= (boot_nxt == BOOT_RUN);
            if (!strap_done_r) begin
                strap_done_r <= 1'b1;
                boot_mode_o  <= boot_mode_i;
            end
        end
    end

    // ********************************
    // Security word into test clock
    // ********************************
    logic [31:0] sec_r;

    word_xfer u_xfer (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .word_i   (security_i),
        .tck_i    (tck_i),
        .trst_n_i (trst_n_i),
        .word_o   (sec_r)
    );

    // ********************************
    // Controller, test clock
    // ********************************
    tap_t state_r;
    tap_t state_nxt;

    // RQ16: standard state walk
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            TLR:    state_nxt = tms_i ? TLR    : RTI;
            RTI:    state_nxt = tms_i ? SEL_DR : RTI;
            SEL_DR: state_nxt = tms_i ? SEL_IR : CAP_DR;
            CAP_DR: state_nxt = tms_i ? EX1_DR : SH_DR;
            SH_DR:  state_nxt = tms_i ? EX1_DR : SH_DR;
            EX1_DR: state_nxt = tms_i ? UPD_DR : PA_DR;
            PA_DR:  state_nxt = tms_i ? EX2_DR : PA_DR;
            EX2_DR: state_nxt = tms_i ? UPD_DR : SH_DR;
            UPD_DR: state_nxt = tms_i ? SEL_DR : RTI;
            SEL_IR: state_nxt = tms_i ? TLR    : CAP_IR;
            CAP_IR: state_nxt = tms_i ? EX1_IR : SH_IR;
            SH_IR:  state_nxt = tms_i ? EX1_IR : SH_IR;
            EX1_IR: state_nxt = tms_i ? UPD_IR : PA_IR;
            PA_IR:  state_nxt = tms_i ? EX2_IR : PA_IR;
            EX2_IR: state_nxt = tms_i ? UPD_IR : SH_IR;
            UPD_IR: state_nxt = tms_i ? SEL_DR : RTI;
        endcase
    end

    // ********************************
    // Decodes
    // ********************************
    logic [IR_W-1:0]  ir_r;
    logic [IR_W-1:0]  ir_sh_r;
    logic [DR_W-1:0]  dr_r;
    logic [BSR_W-1:0] pin_m_r;
    logic [BSR_W-1:0] pin_s_r;

    // RQ13: locked part sees bypass only
    wire             locked   = sec_r[SEC_JTAG_OFF];
    wire [IR_W-1:0]  ir_eff   = locked ? OP_BYPASS : ir_r;
    wire             sel_id   = (ir_eff == OP_DEVICE_IDENTIFICATION);
    wire             sel_user = (ir_eff == OP_USERCODE);
    wire             sel_bsr  = (ir_eff == OP_EXTEST) || (ir_eff == OP_SAMPLE);
    wire             sel_chip = (ir_eff == OP_CHIP);
    wire             sel_otp  = (ir_eff == OP_OTP);
    wire             sel_32   = sel_id || sel_user;

    // RQ7: usercode layout
    // RQ8: user ID from security word
    // RQ12: extension bits feed usercode
    wire [DR_W-1:0]  user_val = {sec_r[UID_LSB +: UID_W], {UNUSED_W{1'b0}}, REV_VAL};

    // RQ6: identification capture
    // RQ15: fixed identification layout
    wire [DR_W-1:0]  cap_val  = sel_id   ? ID_VALUE :
                                sel_user ? user_val :
                                sel_bsr  ? {{(DR_W-BSR_W){1'b0}}, pin_s_r} :
                                           {DR_W{1'b0}};

    // RQ2: path length by instruction
    wire [DR_W-1:0]  sh_32    = {tdi_i, dr_r[DR_W-1:1]};
    wire [DR_W-1:0]  sh_bsr   = {{(DR_W-BSR_W){1'b0}}, tdi_i, dr_r[BSR_W-1:1]};
    wire [DR_W-1:0]  sh_1     = {{(DR_W-1){1'b0}}, tdi_i};
    wire [DR_W-1:0]  sh_val   = sel_32 ? sh_32 : sel_bsr ? sh_bsr : sh_1;

    wire             in_shdr  = (state_r == SH_DR);
    wire             in_shir  = (state_r == SH_IR);

    // ********************************
    // Registers, test clock rising edge
    // ********************************
    // RQ5: held in reset while test reset low
    always_ff @(posedge tck_i or negedge trst_n_i) begin
        if (!trst_n_i) begin
            state_r <= TLR;
            ir_r    <= OP_DEVICE_IDENTIFICATION;
            ir_sh_r <= '0;
            dr_r    <= '0;
            pin_m_r <= '0;
            pin_s_r <= '0;
        end else begin
            state_r <= state_nxt;
            pin_m_r <= pin_in_i;
            pin_s_r <= pin_m_r;
            // RQ2: four-bit instruction capture
            if (state_r == CAP_IR) begin
                ir_sh_r <= IR_CAPTURE;
            end else if (in_shir) begin
                ir_sh_r <= {tdi_i, ir_sh_r[IR_W-1:1]};
            end
            if (state_r == TLR) begin
                ir_r <= OP_DEVICE_IDENTIFICATION;
            end else if (state_r == UPD_IR) begin
                ir_r <= ir_sh_r;
            end
            // RQ16: capture then shift
            if (state_r == CAP_DR) begin
                dr_r <= cap_val;
            end else if (in_shdr) begin
                dr_r <= sh_val;
            end
        end
    end

    // ********************************
    // Boundary cells and forward controls
    // ********************************
    always_ff @(posedge tck_i or negedge trst_n_i) begin
        if (!trst_n_i) begin
            pin_out_o    <= '0;
            extest_o     <= 1'b0;
            chip_sel_o   <= 1'b0;
            chip_shift_o <= 1'b0;
            chip_tdi_o   <= 1'b0;
            otp_access_o <= 1'b0;
        end else begin
            // RQ1: boundary update
            if (state_r == UPD_DR && sel_bsr) begin
                pin_out_o <= dr_r[BSR_W-1:0];
            end
            extest_o     <= (ir_eff == OP_EXTEST);
            // RQ3: chip port forwarding
            chip_sel_o   <= sel_chip;
            chip_shift_o <= sel_chip && (state_nxt == SH_DR);
            chip_tdi_o   <= tdi_i;
            // RQ14: programmable memory gate
            otp_access_o <= sel_otp && !sec_r[SEC_OTP_OFF];
        end
    end

    // ********************************
    // Output on test clock falling edge
    // ********************************
    wire tdo_val = in_shir ? ir_sh_r[0] :
                   sel_chip ? chip_tdo_i : dr_r[0];

    always_ff @(negedge tck_i or negedge trst_n_i) begin
        if (!trst_n_i) begin
            tdo_o    <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else begin
            tdo_o    <= tdo_val;
            tdo_oe_o <= in_shir || in_shdr;
        end
    end

    // ********************************
    // Assertions
    // ********************************
    sequence s_five_tms;
        tms_i [*5];
    endsequence

    property p_tlr_on_tms;
        @(posedge tck_i) disable iff (!trst_n_i)
        s_five_tms |=> (state_r == TLR);
    endproperty
    a_tlr_on_tms: assert property (p_tlr_on_tms) // RQ16
        else $error("five tms highs did not reach reset state");

    property p_ir_reset;
        @(posedge tck_i) disable iff (!trst_n_i)
        (state_r == TLR) |=> (ir_r == OP_DEVICE_IDENTIFICATION);
    endproperty
    a_ir_reset: assert property (p_ir_reset) // RQ6
        else $error("instruction not identification after reset state");

    sequence s_cap_id;
        (state_r == CAP_DR) && sel_id;
    endsequence

    property p_cap_id;
        @(posedge tck_i) disable iff (!trst_n_i)
        s_cap_id |=> (dr_r == ID_VALUE) && dr_r[0];
    endproperty
    a_cap_id: assert property (p_cap_id) // RQ15
        else $error("identification value not captured");

    property p_cap_user;
        @(posedge tck_i) disable iff (!trst_n_i)
        (state_r == CAP_DR) && sel_user
            |=> (dr_r[31:22] == $past(sec_r[31:22])) && (dr_r[21:0] == {4'h0, REV_VAL});
    endproperty
    a_cap_user: assert property (p_cap_user) // RQ8
        else $error("usercode value wrong");

    property p_ir_cap;
        @(posedge tck_i) disable iff (!trst_n_i)
        (state_r == CAP_IR) |=> (ir_sh_r == IR_CAPTURE);
    endproperty
    a_ir_cap: assert property (p_ir_cap) // RQ2
        else $error("instruction capture pattern wrong");

    property p_lock_chip;
        @(posedge tck_i) disable iff (!trst_n_i)
        locked ##1 locked |-> !chip_sel_o && !otp_access_o;
    endproperty
    a_lock_chip: assert property (p_lock_chip) // RQ13
        else $error("test access open on locked part");

    property p_otp_off;
        @(posedge tck_i) disable iff (!trst_n_i)
        sec_r[SEC_OTP_OFF] |=> !otp_access_o;
    endproperty
    a_otp_off: assert property (p_otp_off) // RQ14
        else $error("memory access open while blocked");

    property p_boot_lock;
        @(posedge clock_i) disable iff (!rst_n_i)
        $rose(boot_run_o) |-> $past(lock_s_r);
    endproperty
    a_boot_lock: assert property (p_boot_lock) // RQ10
        else $error("boot began without clock lock");

    property p_boot_stays;
        @(posedge clock_i) disable iff (!rst_n_i)
        boot_run_o |=> boot_run_o;
    endproperty
    a_boot_stays: assert property (p_boot_stays) // RQ9
        else $error("boot dropped without reset");

endmodule
`default_nettype wire

// File: logic/tap_pkg.sv
// Constants shared by the test access port and its word crossing
package tap_pkg;

    // ********************************
    // Register widths
    // ********************************
    localparam int IR_W    = 4;
    localparam int DR_W    = 32;
    localparam int BSR_W   = 8;
    localparam int BOOT_W  = 2;

    // ********************************
    // Instruction codes
    // ********************************
    localparam logic [3:0] OP_EXTEST   = 4'h0;
    localparam logic [3:0] OP_SAMPLE   = 4'h1;
    localparam logic [3:0] OP_DEVICE_IDENTIFICATION   = 4'h2;
    localparam logic [3:0] OP_USERCODE = 4'h3;
    localparam logic [3:0] OP_CHIP     = 4'h4;
    localparam logic [3:0] OP_OTP      = 4'h5;
    localparam logic [3:0] OP_BYPASS   = 4'hF;
    localparam logic [3:0] IR_CAPTURE  = 4'h1;

    // ********************************
    // Identification value, arbitrary codes
    // ********************************
    localparam logic [3:0]  ID_VERSION = 4'h0;
    localparam logic [15:0] ID_PART    = 16'h0ABC;
    localparam logic [10:0] ID_MAKER   = 11'h055;
    localparam logic [31:0] ID_VALUE   = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

    // ********************************
    // Usercode layout, revision arbitrary
    // ********************************
    localparam int          UID_LSB  = 22;
    localparam int          UID_W    = 10;
    localparam int          UNUSED_W = 4;
    localparam int          REV_W    = 18;
    localparam logic [17:0] REV_VAL  = 18'h00001;

    // ********************************
    // Security register bits and reset value
    // ********************************
    localparam int          SEC_JTAG_OFF = 0;
    localparam int          SEC_OTP_OFF  = 13;
    localparam logic [31:0] SEC_RST      = 32'h00000001;

    // ********************************
    // Reset hold times seen by the far side
    // ********************************
    localparam int RST_HOLD_NS = 100;
    localparam int CLK_NS      = 100;
    localparam int RST_HOLD_CY = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;

    // ********************************
    // Boot sequencer states
    // ********************************
    typedef enum logic [1:0] {
        BOOT_IDLE = 2'b00,
        BOOT_LOCK = 2'b01,
        BOOT_RUN  = 2'b11
    } boot_t;

    // ********************************
    // Test port controller states
    // ********************************
    typedef enum logic [3:0] {
        EX2_DR = 4'h0, EX1_DR = 4'h1, SH_DR  = 4'h2, PA_DR  = 4'h3,
        SEL_IR = 4'h4, UPD_DR = 4'h5, CAP_DR = 4'h6, SEL_DR = 4'h7,
        EX2_IR = 4'h8, EX1_IR = 4'h9, SH_IR  = 4'hA, PA_IR  = 4'hB,
        RTI    = 4'hC, UPD_IR = 4'hD, CAP_IR = 4'hE, TLR    = 4'hF
    } tap_t;

endpackage

// File: logic/word_xfer.sv
// Toggle handshake that carries the security word into the test clock
`timescale 1ns/1ps
`default_nettype none
module word_xfer
    import tap_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic [31:0] word_i,
    input  wire logic        tck_i,
    input  wire logic        trst_n_i,
    output logic      [31:0] word_o
);

    // ********************************
    // Source side
    // ********************************
    logic [31:0] hold_r;
    logic        req_r;
    logic        ack_m_r;
    logic        ack_s_r;
    logic        req_m_r;
    logic        req_s_r;
    logic        ack_r;
    wire         idle = (req_r == ack_s_r);

    // Resend whenever idle, so a test reset sees fresh data
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_r  <= SEC_RST;
            req_r   <= 1'b0;
            ack_m_r <= 1'b0;
            ack_s_r <= 1'b0;
        end else begin
            ack_m_r <= ack_r;
            ack_s_r <= ack_m_r;
            if (idle) begin
                hold_r <= word_i;
                req_r  <= ~req_r;
            end
        end
    end

    // ********************************
    // Test clock side
    // ********************************
    wire  fresh = (req_s_r != ack_r);

    always_ff @(posedge tck_i or negedge trst_n_i) begin
        if (!trst_n_i) begin
            req_m_r <= 1'b0;
            req_s_r <= 1'b0;
            ack_r   <= 1'b0;
            word_o  <= SEC_RST;
        end else begin
            req_m_r <= req_r;
            req_s_r <= req_m_r;
            if (fresh) begin
                word_o <= hold_r;
                ack_r  <= req_s_r;
            end
        end
    end

endmodule
`default_nettype wire

// File: verif/jtag_host.sv
// Test controller model that drives the link pins
`timescale 1ns/1ps
`default_nettype none
module jtag_host
    import tap_pkg::*;
(
    output logic      tck_o,
    output logic      trst_n_o,
    output logic      tms_o,
    output logic      tdi_o,
    input  wire logic tdo_i
);
    initial begin
        tck_o = 1'b0;
        trst_n_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end

    task automatic trst_pulse();
        trst_n_o = 1'b0;
        #(RST_HOLD_NS);
        trst_n_o = 1'b1;
        #20;
    endtask

    // one clock, tdo taken at rising edge
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #15;
        tdo = tdo_i;
        tck_o = 1'b1;
        #15;
        tck_o = 1'b0;
    endtask

    // Idle cycles; tdi toggles since nobody reads it
    task automatic run(input logic tms, input int n);
        logic b;
        repeat (n) step(tms, ~tdi_o, b);
    endtask

    // capture, shift LSB first, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic b;
        dout = '0;
        step(1'b1, 1'b0, b);
        if (ir) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask
endmodule
`default_nettype wire

// File: verif/jtag_tap_debug_access_test.sv
// Self-checking bench for the test port and boot sequencer
`timescale 1ns/1ps
`default_nettype none
module jtag_tap_debug_access_test;
    import tap_pkg::*;
    logic              clock_i, rst_n_i, pll_lock_i, chip_tdo_i;
    logic [1:0]        boot_mode_i, boot_mode_o, strap;
    logic [31:0]       security_i, sec, d, dout;
    logic [7:0]        pin_in_i, pin_out_o;
    logic              tck, trst_n, tms, tdi, tdo, tdo_oe, tdo_w;
    logic              extest_o, chip_sel_o, chip_shift_o, chip_tdi_o;
    logic              otp_access_o, boot_run_o, b, c;
    int                mismatches = 0;
    int                checks_done = 0;
    int                cyc;

    // Released line shows a changing level
    assign tdo_w = tdo_oe ? tdo : tck;

    jtag_host host (.tck_o(tck), .trst_n_o(trst_n), .tms_o(tms), .tdi_o(tdi),
                    .tdo_i(tdo_w));

    tap_debug uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .pll_lock_i(pll_lock_i),
        .boot_mode_i(boot_mode_i), .security_i(security_i), .tck_i(tck),
        .trst_n_i(trst_n), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
        .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .extest_o(extest_o),
        .chip_tdo_i(chip_tdo_i), .chip_sel_o(chip_sel_o),
        .chip_shift_o(chip_shift_o), .chip_tdi_o(chip_tdi_o),
        .otp_access_o(otp_access_o), .boot_run_o(boot_run_o),
        .boot_mode_o(boot_mode_o));

    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Expected scan result per instruction
    function automatic logic [31:0] model(input logic [3:0] op, input logic [31:0] s,
                                         input logic [7:0] p, input logic [31:0] di);
        if (s[SEC_JTAG_OFF])
            op = OP_BYPASS;
        case (op)
            OP_DEVICE_IDENTIFICATION:            return {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
            OP_USERCODE:          return {s[31:22], 4'h0, REV_VAL};
            OP_EXTEST, OP_SAMPLE: return {24'h0, p};
            default:              return {di[30:0], 1'b0};
        endcase
    endfunction

    // Hand a security word across; tck idles in the given tms level
    task automatic set_sec(input logic [31:0] v, input logic tms_lvl);
        @(posedge clock_i);
        #1;
        security_i = v;
        repeat (2) begin
            repeat (4) @(posedge clock_i);
            host.run(tms_lvl, 6);
        end
        host.run(1'b0, 1);
    endtask

    // Load instruction, then scan the data path and compare
    task automatic do_op(input logic [3:0] op, input int n, output logic [31:0] di);
        logic [31:0] o, e;
        di = $urandom;
        host.scan(1'b1, IR_W, {28'h0, op}, o);
        if (!security_i[SEC_JTAG_OFF])
            cmp_w(o, {28'h0, IR_CAPTURE});
        host.scan(1'b0, n, di, o);
        e = model(op, security_i, pin_in_i, di);
        if (n < 32)
            e = e & ((32'h1 << n) - 1);
        cmp_w(o, e);
    endtask

    task automatic wait_boot();
        cyc = 0;
        while (boot_run_o !== 1'b1 && cyc < 10) begin
            @(posedge clock_i);
            #1;
            cyc++;
        end
        cmp_w(cyc, 3);
        if (cyc == 10)
            test_done();
    endtask

    initial begin
        rst_n_i = 1'b0;
        pll_lock_i = 1'b0;
        security_i = 32'h0;
        pin_in_i = 8'h0;
        chip_tdo_i = 1'b0;
        d = $urandom(96);
        strap = $urandom;
        boot_mode_i = strap;
        repeat (4) @(posedge clock_i);
        #1;
        cmp_w({31'h0, tdo_oe}, 32'h0);
        cmp_w({31'h0, boot_run_o}, 32'h0);
        rst_n_i = 1'b1;
        host.trst_pulse();
        repeat (3) @(posedge clock_i);
        #1;
        cmp_w({30'h0, boot_mode_o}, {30'h0, strap});
        cmp_w({31'h0, boot_run_o}, 32'h0);
        pll_lock_i = 1'b1;
        wait_boot();
        sec = $urandom;
        sec[SEC_JTAG_OFF] = 1'b0;
        pin_in_i = $urandom;
        set_sec(sec, 1'b1);
        do_op(OP_DEVICE_IDENTIFICATION, DR_W, d);
        do_op(OP_USERCODE, DR_W, d);
        do_op(OP_SAMPLE, BSR_W, d);
        cmp_w({31'h0, extest_o}, 32'h0);
        do_op(OP_EXTEST, BSR_W, d);
        cmp_w({31'h0, extest_o}, 32'h1);
        cmp_w({24'h0, pin_out_o}, {24'h0, d[7:0]});
        do_op(OP_BYPASS, DR_W, d);
        do_op(4'h9, DR_W, d);
        host.scan(1'b1, IR_W, {28'h0, OP_CHIP}, dout);
        // Forward controls follow the instruction one test clock late
        host.run(1'b0, 1);
        cmp_w({31'h0, chip_sel_o}, 32'h1);
        b = $urandom;
        chip_tdo_i = b;
        host.scan(1'b0, 8, $urandom, dout);
        cmp_w(dout, {24'h0, {8{b}}});
        // Chip port shifts and takes tdi while the data path shifts
        host.step(1'b1, 1'b0, c);
        host.step(1'b0, 1'b0, c);
        host.step(1'b0, ~b, c);
        cmp_w({30'h0, chip_shift_o, chip_tdi_o}, {30'h0, 1'b1, ~b});
        host.run(1'b1, 2);
        host.run(1'b0, 1);
        cmp_w({31'h0, chip_shift_o}, 32'h0);
        for (int k = 0; k < 2; k++) begin
            sec[SEC_OTP_OFF] = k[0];
            set_sec(sec, 1'b1);
            host.scan(1'b1, IR_W, {28'h0, OP_OTP}, dout);
            host.run(1'b0, 1);
            cmp_w({31'h0, otp_access_o}, {31'h0, ~k[0]});
        end
        // Unprogrammed user field reads zero
        set_sec(32'h0, 1'b1);
        do_op(OP_USERCODE, DR_W, d);
        set_sec(sec | 32'h1, 1'b1);
        do_op(OP_DEVICE_IDENTIFICATION, DR_W, d);
        host.scan(1'b1, IR_W, {28'h0, OP_CHIP}, dout);
        host.run(1'b0, 1);
        cmp_w({31'h0, chip_sel_o}, 32'h0);
        // Test reset mid-run falls back to the identification path
        set_sec(sec, 1'b1);
        host.scan(1'b1, IR_W, {28'h0, OP_USERCODE}, dout);
        host.trst_pulse();
        set_sec(sec, 1'b0);
        host.scan(1'b0, DR_W, 32'h0, dout);
        cmp_w(dout, model(OP_DEVICE_IDENTIFICATION, sec, 8'h0, 32'h0));
        @(posedge clock_i);
        #1;
        rst_n_i = 1'b0;
        #1;
        cmp_w({31'h0, boot_run_o}, 32'h0);
        @(posedge clock_i);
        #1;
        rst_n_i = 1'b1;
        @(posedge clock_i);
        #1;
        cmp_w({30'h0, boot_mode_o}, {30'h0, strap});
        test_done();
    end
endmodule
`default_nettype wire
